// ---- rtl/pcx_map.vh ----
// Constants for the program control execution unit
`ifndef PCX_MAP_VH
`define PCX_MAP_VH

// ----------------------------------------------------------------------------
// Instruction word fields, bit 35 is the leftmost bit of the word
// ----------------------------------------------------------------------------
`define PCX_OP_HI          35
`define PCX_OP_LO          27
`define PCX_AC_HI          26
`define PCX_AC_LO          23
`define PCX_IND_BIT        22
`define PCX_IDX_HI         21
`define PCX_IDX_LO         18
`define PCX_ADR_HI         17
`define PCX_ADR_LO         0

// ----------------------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------------------
`define PCX_OP_EXEC_AT     9'h0_AE
`define PCX_OP_FIND_ONE    9'h0_A3
`define PCX_OP_FLAG_CLR    9'h0_AD
`define PCX_OP_SITE_A      9'h0_A7
`define PCX_OP_SITE_B      9'h0_AF

// ----------------------------------------------------------------------------
// Flag vector bits, aligned with the flag-select field
// ----------------------------------------------------------------------------
`define PCX_FLG_OVF        3
`define PCX_FLG_CRY0       2
`define PCX_FLG_CRY1       1
`define PCX_FLG_FOV        0

// ----------------------------------------------------------------------------
// Register byte offsets and reset values
// ----------------------------------------------------------------------------
`define PCX_REG_CTRL       8'h00
`define PCX_REG_FLAGS      8'h04
`define PCX_REG_STATUS     8'h08
`define PCX_REG_CHAIN      8'h0C
`define PCX_REG_RETPC      8'h10
`define PCX_RST_CTRL       32'h0000_0001
`define PCX_RST_FLAGS      4'h0

`endif

// ---- rtl/pcx_exec_unit.v ----
// Program control execution unit with its APB register slave
//
// Notes on behaviour
// RULE1 - Execute opcode with zero field or user mode runs the word at E next.
// RULE2 - Any instruction may be an execute target, chains of any length work.
// RULE3 - A skip in a chain is relative to the first execute instruction.
// RULE4 - A jump saving the counter in a chain saves first execute address plus one.
// RULE5 - Executive mode with nonzero field hands off to previous-context execute.
// RULE6 - User mode ignores the field of the execute opcode.
// RULE7 - Find-first-one on zero clears the next accumulator, goes on in sequence.
// RULE8 - Nonzero: leading zero count into next accumulator, then jump to E.
// RULE9 - Find-first-one never alters the tested accumulator.
// RULE10 - Negative value gives count zero and the jump is taken.
// RULE11 - Flag jump: any chosen flag set clears chosen flags and jumps to E.
// RULE12 - Select bits 9..12 pick overflow, carry zero, carry one, float overflow.
// RULE13 - Flag jump with empty select is a no-op touching no memory operand.
// RULE14 - Selecting all flags with target next address just clears them.
// RULE15 - Flag jump saves neither return address nor flags.
// RULE16 - The two site-specific opcodes execute as no-ops.
// RULE17 - A subroutine call saves the address after the call.
// RULE18 - An interrupt saves the address of the interrupted instruction.
// RULE19 - Exactly one carry set by one instruction also sets overflow.
// RULE20 - Word splits into opcode, field, indirect, index and address.
// RULE21 - Next accumulator is the field plus one, modulo sixteen.
//
// Design decisions made here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "pcx_map.vh"

module pcx_exec_unit (
   input  wire        CORE_CLK_IN,
   input  wire        RESET_N_IN,
   // APB slave
   input  wire        PSEL_IN,
   input  wire        PENABLE_IN,
   input  wire        PWRITE_IN,
   input  wire [7:0]  PADDR_IN,
   input  wire [31:0] PWDATA_IN,
   output wire [31:0] PRDATA_OUT,
   output wire        PREADY_OUT,
   output wire        PSLVERR_OUT,
   // Instruction from fetch and decode
   input  wire        INSTR_VALID_IN,
   input  wire [35:0] INSTR_WORD_IN,
   input  wire [17:0] INSTR_ADDR_IN,
   input  wire [17:0] INSTR_EA_IN,
   input  wire [35:0] AC_DATA_IN,
   input  wire        USER_MODE_IN,
   input  wire        INTR_SAVE_IN,
   // Carry and overflow events from the arithmetic unit
   input  wire        ARITH_DONE_IN,
   input  wire        ARITH_CRY0_IN,
   input  wire        ARITH_CRY1_IN,
   input  wire        ARITH_OVF_IN,
   input  wire        ARITH_FOV_IN,
   // Results
   output wire        DONE_OUT,
   output wire        PC_LOAD_OUT,
   output wire [17:0] NEXT_PC_OUT,
   output wire        XCT_FETCH_OUT,
   output wire [17:0] XCT_ADDR_OUT,
   output wire        PREVIOUS_CONTEXT_EXECUTE_OUT,
   output wire        FOREIGN_OUT,
   output wire [17:0] SKIP_PC_OUT,
   output wire [17:0] RETURN_PC_OUT,
   output wire        OPERAND_REF_OUT,
   output wire        AC_WE_OUT,
   output wire [3:0]  AC_WADDR_OUT,
   output wire [35:0] AC_WDATA_OUT,
   output wire [3:0]  FLAGS_OUT
);

   // -------------------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------------------
   function [5:0] lead_zeros;
      input [35:0] w;
      integer i;
      reg     hit;
      begin
         lead_zeros = 6'd0;
         hit = 1'b0;
         for (i = 35; i >= 0; i = i - 1) begin
            if (!hit && w[i]) begin
               hit = 1'b1;
               lead_zeros = 6'd35 - i[5:0];
            end
         end
         if (!hit)
            lead_zeros = 6'd0;
      end
   endfunction

   function [17:0] addr_inc;
      input [17:0] a;
      begin
         addr_inc = a + 18'h0_0001;
      end
   endfunction

   // -------------------------------------------------------------------------
   // Instruction fields
   // -------------------------------------------------------------------------
   wire [8:0] op_w  = INSTR_WORD_IN[`PCX_OP_HI:`PCX_OP_LO];   // [RULE20]
   wire [3:0] fld_w = INSTR_WORD_IN[`PCX_AC_HI:`PCX_AC_LO];   // [RULE20]
   // Indirect, index and address fields resolve upstream into INSTR_EA_IN

   reg        ctrl_en_q;
   reg  [3:0] flags_q;
   reg  [3:0] flags_d;
   reg        chain_q;
   reg [17:0] chain_base_q;
   reg        done_q;
   reg        pc_load_q;
   reg [17:0] next_pc_q;
   reg        xct_fetch_q;
   reg [17:0] xct_addr_q;
   reg        previous_context_execute_q;
   reg        foreign_q;
   reg [17:0] skip_pc_q;
   reg [17:0] ret_pc_q;
   reg        opref_q;
   reg        ac_we_q;
   reg  [3:0] ac_waddr_q;
   reg [35:0] ac_wdata_q;
   reg [31:0] prdata_q;
   reg        pready_q;
   reg        pslverr_q;

   wire       go       = INSTR_VALID_IN & ctrl_en_q;
   // A chain keeps the first execute address, all later steps refer to it
   wire [17:0] origin  = chain_q ? chain_base_q : INSTR_ADDR_IN;   // [RULE3]
   wire       is_xct   = (op_w == `PCX_OP_EXEC_AT);
   wire       xct_run  = is_xct & ((fld_w == 4'h0) | USER_MODE_IN); // [RULE1] [RULE6]
   wire       xct_prev = is_xct & ~xct_run;                          // [RULE5]
   wire       is_ffo   = (op_w == `PCX_OP_FIND_ONE);
   wire       is_jfc   = (op_w == `PCX_OP_FLAG_CLR);
   wire       is_site  = (op_w == `PCX_OP_SITE_A) | (op_w == `PCX_OP_SITE_B);
   wire       ours     = is_xct | is_ffo | is_jfc | is_site;
   wire       jfc_hit  = is_jfc & |(fld_w & flags_q);                // [RULE11] [RULE12]
   wire       ffo_hit  = is_ffo & |AC_DATA_IN;

   // -------------------------------------------------------------------------
   // APB decode
   // -------------------------------------------------------------------------
   wire       apb_setup = PSEL_IN & ~PENABLE_IN;
   wire       apb_wr    = PSEL_IN & PENABLE_IN & pready_q & PWRITE_IN;
   wire       map_hit   = (PADDR_IN == `PCX_REG_CTRL)   | (PADDR_IN == `PCX_REG_FLAGS) |
                          (PADDR_IN == `PCX_REG_STATUS) | (PADDR_IN == `PCX_REG_CHAIN) |
                          (PADDR_IN == `PCX_REG_RETPC);
   reg [31:0] rd_mux;

   always @* begin
      case (PADDR_IN)
         `PCX_REG_CTRL:   rd_mux = {31'h0000_0000, ctrl_en_q};
         `PCX_REG_FLAGS:  rd_mux = {28'h000_0000, flags_q};
         `PCX_REG_STATUS: rd_mux = {30'h0000_0000, done_q, chain_q};
         `PCX_REG_CHAIN:  rd_mux = {14'h0000, chain_base_q};
         `PCX_REG_RETPC:  rd_mux = {14'h0000, ret_pc_q};
         default:         rd_mux = 32'h0000_0000;
      endcase
   end

   // -------------------------------------------------------------------------
   // Flag update: arithmetic sets win over clears by the flag jump or software
   // -------------------------------------------------------------------------
   always @* begin
      flags_d = flags_q;
      if (apb_wr && PADDR_IN == `PCX_REG_FLAGS)
         flags_d = PWDATA_IN[3:0];
      if (go && jfc_hit)
         flags_d = flags_d & ~fld_w;                                 // [RULE11] [RULE14]
      if (ARITH_DONE_IN) begin
         flags_d[`PCX_FLG_CRY0] = flags_d[`PCX_FLG_CRY0] | ARITH_CRY0_IN;
         flags_d[`PCX_FLG_CRY1] = flags_d[`PCX_FLG_CRY1] | ARITH_CRY1_IN;
         flags_d[`PCX_FLG_FOV]  = flags_d[`PCX_FLG_FOV] | ARITH_FOV_IN;
         flags_d[`PCX_FLG_OVF]  = flags_d[`PCX_FLG_OVF] | ARITH_OVF_IN | ARITH_FOV_IN |
                                  (ARITH_CRY0_IN ^ ARITH_CRY1_IN);   // [RULE19]
      end
   end

   // -------------------------------------------------------------------------
   // Registers and APB slave
   // -------------------------------------------------------------------------
   always @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         ctrl_en_q <= 1'b1;
         flags_q   <= `PCX_RST_FLAGS;
         prdata_q  <= 32'h0000_0000;
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         flags_q  <= flags_d;
         // Read data is taken at setup so the access phase needs no wait state
         // Zero wait states: ready is raised for the access phase only
         pready_q <= apb_setup;
         if (apb_setup) begin
            prdata_q  <= PWRITE_IN ? 32'h0000_0000 : rd_mux;
            pslverr_q <= ~map_hit;
         end
         if (apb_wr && PADDR_IN == `PCX_REG_CTRL)
            ctrl_en_q <= PWDATA_IN[0];
      end
   end

   // -------------------------------------------------------------------------
   // Execution, next values
   // -------------------------------------------------------------------------
   reg        chain_d;
   reg [17:0] chain_base_d;
   reg        pc_load_d;
   reg [17:0] next_pc_d;
   reg        xct_fetch_d;
   reg [17:0] xct_addr_d;
   reg        previous_context_execute_d;
   reg        foreign_d;
   reg [17:0] skip_pc_d;
   reg [17:0] ret_pc_d;
   reg        opref_d;
   reg        ac_we_d;
   reg  [3:0] ac_waddr_d;
   reg [35:0] ac_wdata_d;

   always @* begin
      // Pulses drop unless an accepted instruction raises them; data holds
      chain_d      = chain_q;
      chain_base_d = chain_base_q;
      pc_load_d    = 1'b0;
      next_pc_d    = next_pc_q;
      xct_fetch_d  = 1'b0;
      xct_addr_d   = xct_addr_q;
      previous_context_execute_d       = 1'b0;
      foreign_d    = 1'b0;
      skip_pc_d    = skip_pc_q;
      ret_pc_d     = ret_pc_q;
      opref_d      = 1'b0;
      ac_we_d      = 1'b0;
      ac_waddr_d   = ac_waddr_q;
      ac_wdata_d   = ac_wdata_q;
      if (go) begin
         next_pc_d  = addr_inc(origin);
         xct_addr_d = INSTR_EA_IN;
         // Chain lives on only while execute targets are execute opcodes
         chain_d    = xct_run;                                          // [RULE2]
         if (xct_run && !chain_q)
            chain_base_d = INSTR_ADDR_IN;
         // The flag jump is a bare branch, so the saved counters stay put
         if (!is_jfc) begin
            skip_pc_d = addr_inc(addr_inc(origin));                     // [RULE3]
            ret_pc_d  = INTR_SAVE_IN ? origin : addr_inc(origin);       // [RULE4] [RULE17] [RULE18]
         end
         if (xct_run) begin
            xct_fetch_d = 1'b1;                                         // [RULE1]
         end else if (xct_prev) begin
            previous_context_execute_d = 1'b1;                                              // [RULE5]
         end else if (is_ffo) begin
            // Only the following accumulator is written
            ac_we_d    = 1'b1;                                          // [RULE9]
            ac_waddr_d = fld_w + 4'h1;                                  // [RULE21]
            ac_wdata_d = ffo_hit ? {30'h0000_0000, lead_zeros(AC_DATA_IN)} :
                                   36'h0_0000_0000;                     // [RULE7] [RULE8] [RULE10]
            pc_load_d  = 1'b1;
            next_pc_d  = ffo_hit ? INSTR_EA_IN : addr_inc(origin);      // [RULE8]
         end else if (is_jfc) begin
            // No operand, no saved state; only a branch
            pc_load_d = 1'b1;                                           // [RULE13] [RULE15]
            next_pc_d = jfc_hit ? INSTR_EA_IN : addr_inc(origin);       // [RULE11]
         end else if (is_site) begin
            pc_load_d = 1'b1;                                           // [RULE16]
         end else begin
            foreign_d = 1'b1;
            opref_d   = ~ours;
         end
      end
   end

   // -------------------------------------------------------------------------
   // Execution registers
   // -------------------------------------------------------------------------
   always @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         chain_q      <= 1'b0;
         chain_base_q <= 18'h0_0000;
         done_q       <= 1'b0;
         pc_load_q    <= 1'b0;
         next_pc_q    <= 18'h0_0000;
         xct_fetch_q  <= 1'b0;
         xct_addr_q   <= 18'h0_0000;
         previous_context_execute_q       <= 1'b0;
         foreign_q    <= 1'b0;
         skip_pc_q    <= 18'h0_0000;
         ret_pc_q     <= 18'h0_0000;
         opref_q      <= 1'b0;
         ac_we_q      <= 1'b0;
         ac_waddr_q   <= 4'h0;
         ac_wdata_q   <= 36'h0_0000_0000;
      end else begin
         chain_q      <= chain_d;
         chain_base_q <= chain_base_d;
         done_q       <= go;
         pc_load_q    <= pc_load_d;
         next_pc_q    <= next_pc_d;
         xct_fetch_q  <= xct_fetch_d;
         xct_addr_q   <= xct_addr_d;
         previous_context_execute_q       <= previous_context_execute_d;
         foreign_q    <= foreign_d;
         skip_pc_q    <= skip_pc_d;
         ret_pc_q     <= ret_pc_d;
         opref_q      <= opref_d;
         ac_we_q      <= ac_we_d;
         ac_waddr_q   <= ac_waddr_d;
         ac_wdata_q   <= ac_wdata_d;
      end
   end

   // -------------------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------------------
   assign PRDATA_OUT      = prdata_q;
   assign PREADY_OUT      = pready_q;
   assign PSLVERR_OUT     = pslverr_q & pready_q;
   assign DONE_OUT        = done_q;
   assign PC_LOAD_OUT     = pc_load_q;
   assign NEXT_PC_OUT     = next_pc_q;
   assign XCT_FETCH_OUT   = xct_fetch_q;
   assign XCT_ADDR_OUT    = xct_addr_q;
   assign PREVIOUS_CONTEXT_EXECUTE_OUT        = previous_context_execute_q;
   assign FOREIGN_OUT     = foreign_q;
   assign SKIP_PC_OUT     = skip_pc_q;
   assign RETURN_PC_OUT   = ret_pc_q;
   assign OPERAND_REF_OUT = opref_q;
   assign AC_WE_OUT       = ac_we_q;
   assign AC_WADDR_OUT    = ac_waddr_q;
   assign AC_WDATA_OUT    = ac_wdata_q;
   assign FLAGS_OUT       = flags_q;

endmodule // pcx_exec_unit

`default_nettype wire

// ---- test/pcx_acc_model.sv ----
// Accumulator file model standing on the far side of the execution unit
`timescale 1ns/1ps
`default_nettype none
module pcx_acc_model (
   input  wire logic        clk_in,
   input  wire logic        we_in,
   input  wire logic [3:0]  waddr_in,
   input  wire logic [35:0] wdata_in,
   input  wire logic [3:0]  raddr_in,
   output logic      [35:0] rdata_out
);
   // Bench preloads entries directly; the unit writes through the port and reads AC_DATA_IN from rdata_out
   logic [35:0] ac_file [16];
   assign rdata_out = ac_file[raddr_in];
   always @(posedge clk_in) begin
      if (we_in === 1'b1) ac_file[waddr_in] <= wdata_in;
   end
endmodule // pcx_acc_model
`default_nettype wire

// ---- test/pcx_exec_unit_sva.sv ----
// Concurrent checks on the ports of the execution unit
`timescale 1ns/1ps
`default_nettype none
`include "pcx_map.vh"
module pcx_exec_chk (
   input wire logic        CORE_CLK_IN,
   input wire logic        RESET_N_IN,
   input wire logic [35:0] INSTR_WORD_IN,
   input wire logic [17:0] INSTR_EA_IN,
   input wire logic [35:0] AC_DATA_IN,
   input wire logic        USER_MODE_IN,
   input wire logic        ARITH_DONE_IN,
   input wire logic        ARITH_CRY0_IN,
   input wire logic        ARITH_CRY1_IN,
   input wire logic        DONE_OUT,
   input wire logic        PC_LOAD_OUT,
   input wire logic [17:0] NEXT_PC_OUT,
   input wire logic        XCT_FETCH_OUT,
   input wire logic [17:0] XCT_ADDR_OUT,
   input wire logic        PREVIOUS_CONTEXT_EXECUTE_OUT,
   input wire logic        FOREIGN_OUT,
   input wire logic        OPERAND_REF_OUT,
   input wire logic        AC_WE_OUT,
   input wire logic [3:0]  AC_WADDR_OUT,
   input wire logic [35:0] AC_WDATA_OUT,
   input wire logic [3:0]  FLAGS_OUT
);
   // Inputs one cycle back line up with the result pulses
   logic [35:0] w_q;
   logic [35:0] ac_q;
   logic [17:0] ea_q;
   logic        u_q;
   logic        ad_q;
   always @(posedge CORE_CLK_IN) begin
      w_q  <= INSTR_WORD_IN;
      ac_q <= AC_DATA_IN;
      ea_q <= INSTR_EA_IN;
      u_q  <= USER_MODE_IN;
      ad_q <= ARITH_DONE_IN;
   end
   wire [8:0] op  = w_q[35:27];
   wire [3:0] fld = w_q[26:23];
   wire is_x = DONE_OUT && op == `PCX_OP_EXEC_AT;
   wire is_f = DONE_OUT && op == `PCX_OP_FIND_ONE;
   wire is_j = DONE_OUT && op == `PCX_OP_FLAG_CLR;
   wire is_s = DONE_OUT && (op == `PCX_OP_SITE_A || op == `PCX_OP_SITE_B);
   default clocking cb @(posedge CORE_CLK_IN); endclocking
   default disable iff (!RESET_N_IN);
   xct_fetch_a: assert property (is_x && (fld == 4'h0 || u_q) |->
      XCT_FETCH_OUT && XCT_ADDR_OUT == ea_q) else $error("execute target not fetched");
   prev_ctx_a: assert property (is_x && fld != 4'h0 && !u_q |->
      PREVIOUS_CONTEXT_EXECUTE_OUT && !XCT_FETCH_OUT) else $error("executive execute not handed off");
   ffo_dest_a: assert property (is_f |->
      AC_WE_OUT && AC_WADDR_OUT == fld + 4'h1) else $error("count written to wrong slot");
   ffo_zero_a: assert property (is_f && ac_q == 36'h0 |->
      AC_WDATA_OUT == 36'h0) else $error("zero word gave nonzero count");
   ffo_neg_a: assert property (is_f && ac_q[35] |->
      AC_WDATA_OUT == 36'h0 && PC_LOAD_OUT && NEXT_PC_OUT == ea_q) else $error("negative case");
   flag_jump_a: assert property (is_j && (fld & $past(FLAGS_OUT)) != 4'h0 && !ad_q |->
      PC_LOAD_OUT && NEXT_PC_OUT == ea_q && (FLAGS_OUT & fld) == 4'h0) else $error("flag jump");
   flag_mem_a: assert property (is_j |-> !OPERAND_REF_OUT && !AC_WE_OUT)
      else $error("flag jump touched an operand");
   site_nop_a: assert property (is_s |-> !AC_WE_OUT && !XCT_FETCH_OUT && !FOREIGN_OUT)
      else $error("site opcode did something");
   ovf_carry_a: assert property (ARITH_DONE_IN && (ARITH_CRY0_IN ^ ARITH_CRY1_IN)
      |=> FLAGS_OUT[3]) else $error("single carry left overflow clear");
   cover property (is_x && XCT_FETCH_OUT);
   cover property (is_f && PC_LOAD_OUT);
   cover property (is_j && PC_LOAD_OUT);
endmodule // pcx_exec_chk
bind pcx_exec_unit pcx_exec_chk u_chk (.CORE_CLK_IN, .RESET_N_IN, .INSTR_WORD_IN, .INSTR_EA_IN,
   .AC_DATA_IN, .USER_MODE_IN, .ARITH_DONE_IN, .ARITH_CRY0_IN, .ARITH_CRY1_IN, .DONE_OUT,
   .PC_LOAD_OUT, .NEXT_PC_OUT, .XCT_FETCH_OUT, .XCT_ADDR_OUT, .PREVIOUS_CONTEXT_EXECUTE_OUT, .FOREIGN_OUT,
   .OPERAND_REF_OUT, .AC_WE_OUT, .AC_WADDR_OUT, .AC_WDATA_OUT, .FLAGS_OUT);
`default_nettype wire

// ---- test/pcx_tb.sv ----
// Self-checking bench for the program control execution unit
`timescale 1ns/1ps
`default_nettype none
`include "pcx_map.vh"
`define CHK(g,e) begin compares++; if ((g) !== (e)) begin err_total++; \
   $display("Error t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb;
   logic clk, rst_n, psel, pen, pwr, iv, um, isv, ad, c0, c1;
   logic [7:0] padr;
   logic [31:0] pwd, prd;
   logic [35:0] iw, acd, wd;
   logic [17:0] ia, iea, npc, xa, spc, rpc;
   logic prdy, perr, done, pcl, xf, px, fo, oref, we;
   logic [3:0] wa, flg;
   int err_total = 0;
   int compares = 0;
   localparam logic [8:0] OP_FR = 9'h104;
   pcx_exec_unit u_dut (.CORE_CLK_IN(clk), .RESET_N_IN(rst_n), .PSEL_IN(psel),
      .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(padr), .PWDATA_IN(pwd), .PRDATA_OUT(prd),
      .PREADY_OUT(prdy), .PSLVERR_OUT(perr), .INSTR_VALID_IN(iv), .INSTR_WORD_IN(iw),
      .INSTR_ADDR_IN(ia), .INSTR_EA_IN(iea), .AC_DATA_IN(acd), .USER_MODE_IN(um),
      .INTR_SAVE_IN(isv), .ARITH_DONE_IN(ad), .ARITH_CRY0_IN(c0), .ARITH_CRY1_IN(c1),
      .ARITH_OVF_IN(1'b0), .ARITH_FOV_IN(1'b0), .DONE_OUT(done), .PC_LOAD_OUT(pcl),
      .NEXT_PC_OUT(npc), .XCT_FETCH_OUT(xf), .XCT_ADDR_OUT(xa), .PREVIOUS_CONTEXT_EXECUTE_OUT(px),
      .FOREIGN_OUT(fo), .SKIP_PC_OUT(spc), .RETURN_PC_OUT(rpc), .OPERAND_REF_OUT(oref),
      .AC_WE_OUT(we), .AC_WADDR_OUT(wa), .AC_WDATA_OUT(wd), .FLAGS_OUT(flg));
   pcx_acc_model u_acc (.clk_in(clk), .we_in(we), .waddr_in(wa), .wdata_in(wd),
      .raddr_in(iw[26:23]), .rdata_out(acd));
   initial begin
      clk = 0;
      forever #4 clk = ~clk;
   end
   task automatic final_report();
      $display("compares=%0d err_total=%0d", compares, err_total);
      if (err_total == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // Request held until pready is seen high at a rising edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [32:0] rsp);
      int n;
      @(posedge clk) begin psel <= 1; pen <= 0; pwr <= w; padr <= a; pwd <= d; end
      @(posedge clk) pen <= 1;
      n = 0;
      do begin @(posedge clk); n++; end while (prdy !== 1'b1 && n < 20);
      if (n >= 20) err_total++;
      rsp = {perr, prd};
      psel <= 0;
      pen <= 0;
   endtask
   // One instruction; results are looked at in the cycle they stand
   task automatic ins(input logic [8:0] op, input logic [3:0] f, input logic [17:0] a, e,
                      input logic u = 0, input logic it = 0);
      @(posedge clk) begin iv <= 1; iw <= {op, f, 5'h00, e}; ia <= a; iea <= e; um <= u; end
      isv <= it;
      @(posedge clk) iv <= 0;
      #1;
   endtask
   initial begin
      logic [32:0] r;
      logic [35:0] v;
      logic [17:0] rp;
      int i, lz;
      {rst_n, psel, pen, pwr, iv, um, isv, ad, c0, c1} = 0;
      {padr, pwd, iw, ia, iea} = 0;
      repeat (6) @(posedge clk);
      rst_n <= 1;
      apb(0, 8'h00, 0, r); `CHK(r, 33'h0_0000_0001)
      apb(0, 8'h04, 0, r); `CHK(r, 33'h0_0000_0000)
      apb(0, 8'h20, 0, r); `CHK(r, 33'h1_0000_0000)
      $display("test registers done");
      ins(`PCX_OP_EXEC_AT, 0, 18'h0_0100, 18'h0_0200); `CHK({xf, xa}, 19'h0_0200 | 19'h4_0000)
      ins(`PCX_OP_EXEC_AT, 5, 18'h0_0200, 18'h0_0300, 1); `CHK({xf, xa, px}, {1'b1, 18'h0_0300, 1'b0})
      ins(OP_FR, 0, 18'h0_0300, 0); `CHK({fo, rpc, spc}, {1'b1, 18'h0_0101, 18'h0_0102})
      ins(`PCX_OP_EXEC_AT, 0, 18'h0_0400, 18'h0_0500);
      ins(OP_FR, 0, 18'h0_0500, 0, 0, 1); `CHK(rpc, 18'h0_0400)
      ins(`PCX_OP_EXEC_AT, 3, 18'h0_0600, 18'h0_0700); `CHK({px, xf}, 2'b10)
      ins(OP_FR, 0, 18'h0_0700, 0);
      $display("test execute chain done");
      for (i = 0; i < 4; i++) begin
         v = i == 0 ? 36'h0 : i == 1 ? 36'h8_0000_0000 : i == 2 ? 36'h1 : 36'h0_0001_2345;
         u_acc.ac_file[15] = v;
         ins(`PCX_OP_FIND_ONE, 4'hF, 18'h0_1000, 18'h0_2000);
         lz = 0;
         while (lz < 36 && v[35 - lz] == 1'b0) lz++;
         `CHK({we, wa, wd}, {1'b1, 4'h0, v == 0 ? 36'h0 : 36'(lz)})
         `CHK(pcl && npc == 18'h0_2000, v != 0)
         @(posedge clk) #1 `CHK(u_acc.ac_file[15], v)
      end
      $display("test find first one done");
      rp = rpc;
      for (i = 0; i < 4; i++) begin
         apb(1, 8'h04, 32'h0000_000F, r);
         ins(`PCX_OP_FLAG_CLR, 4'h8 >> i, 18'h0_3000, 18'h0_3100);
         `CHK({pcl, npc, flg}, {1'b1, 18'h0_3100, 4'hF & ~(4'h8 >> i)})
         `CHK({we, rpc}, {1'b0, rp})
      end
      apb(1, 8'h04, 0, r);
      ins(`PCX_OP_FLAG_CLR, 4'hF, 18'h0_3000, 18'h0_3100); `CHK(pcl && npc == 18'h0_3100, 1'b0)
      apb(1, 8'h04, 32'h0000_000F, r);
      ins(`PCX_OP_FLAG_CLR, 4'hF, 18'h0_3200, 18'h0_3201); `CHK({flg, npc}, {4'h0, 18'h0_3201})
      apb(1, 8'h04, 32'h0000_000F, r);
      ins(`PCX_OP_FLAG_CLR, 0, 18'h0_3300, 18'h2_ABCD);
      `CHK({oref, flg, pcl && npc == 18'h2_ABCD}, {1'b0, 4'hF, 1'b0})
      for (i = 0; i < 2; i++) begin
         ins(i ? `PCX_OP_SITE_B : `PCX_OP_SITE_A, 0, 18'h0_3400, 18'h0_3500);
         `CHK({we, fo, xf, pcl && npc == 18'h0_3500}, 4'h0)
      end
      $display("test flag jump and site codes done");
      apb(1, 8'h04, 0, r);
      @(posedge clk) begin ad <= 1; c0 <= 1; end
      @(posedge clk) begin ad <= 0; c0 <= 0; end
      #1 `CHK(flg[3:2], 2'b11)
      apb(1, 8'h04, 0, r);
      @(posedge clk) begin ad <= 1; c0 <= 1; c1 <= 1; end
      @(posedge clk) begin ad <= 0; c0 <= 0; c1 <= 0; end
      #1 `CHK(flg, 4'h6)
      apb(1, 8'h00, 0, r);
      ins(`PCX_OP_FLAG_CLR, 4'hF, 18'h0_3600, 18'h0_3700); `CHK(done, 1'b0)
      apb(1, 8'h00, 1, r);
      $display("test flags and enable done");
      final_report();
   end
   // Whole run needs well under two thousand cycles
   initial begin
      repeat (5000) @(posedge clk);
      err_total++;
      final_report();
   end
endmodule // tb
`default_nettype wire
